// file: dv/acsm_host_model.sv
// Purpose: receiving host, makes bit clock and frame sync
// Assumes: 4-bit words, 64 slots per frame
// Notes:   bit clock stands low between frames
`timescale 1ns/1ps
module acsm_host_model (
    output logic      bclk,
    output logic      fsync,
    input  wire logic sdout,
    input  wire logic sdout_oe
);
    import acsm_pkg::*;
    logic [255:0] cap_d;
    logic [255:0] cap_o;
    initial begin
        bclk  = 1'b0;
        fsync = 1'b0;
    end
    // one idle bit, then the sync edge, then 256 captured bits
    task automatic frame(input acsm_fmt_t f);
        logic idle;
        idle  = (f == ACSM_FMT_I2S);
        fsync = idle;
        #201;
        for (int i = -1; i < 257; i++) begin
            bclk  = 1'b0;
            fsync = (i < 0) ? idle : (f == ACSM_FMT_TDM) ? (i == 0) : (f == ACSM_FMT_I2S) ? (i >= 128) : (i < 128);
            #32;
            bclk = 1'b1;
            if (i >= 1) begin
                cap_d[i-1] = sdout;
                cap_o[i-1] = sdout_oe;
            end
            #32;
        end
        bclk = 1'b0;
    endtask : frame
endmodule : acsm_host_model

// file: dv/acsm_slot_map_properties.sv
// Purpose: port checks for the slot map
// Assumes: one clock domain, bound to acsm_slot_map
// Notes:   register port reads are combinational
`timescale 1ns/1ps
module acsm_slot_map_chk (
    input wire logic                   clk,
    input wire logic                   nrst,
    input wire acsm_pkg::acsm_reg_req_t reg_req,
    input wire logic [acsm_pkg::REG_W-1:0] reg_rdata,
    input wire logic                   smp_ready,
    input wire logic                   sdout,
    input wire logic                   sdout_oe
);
    import acsm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_RSVD_ZERO: assert property (reg_rdata[7:6] == RSVD_RD)
        else $error("reserved bits read nonzero");
    AST_WR_CH1: assert property ((reg_req.we && reg_req.addr == 8'h0b) ##1 reg_req.addr == 8'h0b
        |-> reg_rdata == {2'h0, $past(reg_req.wdata[5:0])}) else $error("channel 1 write lost");
    AST_WR_CH2: assert property ((reg_req.we && reg_req.addr == 8'h0c) ##1 reg_req.addr == 8'h0c
        |-> reg_rdata == {2'h0, $past(reg_req.wdata[5:0])}) else $error("channel 2 write lost");
    AST_WR_CH3: assert property ((reg_req.we && reg_req.addr == 8'h0d) ##1 reg_req.addr == 8'h0d
        |-> reg_rdata == {2'h0, $past(reg_req.wdata[5:0])}) else $error("channel 3 write lost");
    AST_WR_CH4: assert property ((reg_req.we && reg_req.addr == 8'h0e) ##1 reg_req.addr == 8'h0e
        |-> reg_rdata == {2'h0, $past(reg_req.wdata[5:0])}) else $error("channel 4 write lost");
    AST_RST_VAL: assert property (($past(nrst) == 1'b0 && reg_req.addr inside {[8'h0b:8'h0e]})
        |-> reg_rdata == reg_req.addr - 8'h0b) else $error("slot field reset value wrong");
    AST_UNMAP: assert property (!(reg_req.addr inside {[8'h0b:8'h0e]}) |-> reg_rdata == UNMAPPED_RD)
        else $error("unmapped read nonzero");
    AST_IDLE_ZERO: assert property (!sdout_oe |-> !sdout)
        else $error("data driven outside a claimed slot");
    AST_READY_RST: assert property ($past(nrst) == 1'b0 |-> smp_ready && $stable(sdout_oe))
        else $error("buffer not empty after reset");
endmodule : acsm_slot_map_chk
bind acsm_slot_map acsm_slot_map_chk i_acsm_slot_map_chk (.clk(clk), .nrst(nrst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .smp_ready(smp_ready), .sdout(sdout), .sdout_oe(sdout_oe));

// file: dv/tb_acsm_slot_map.sv
// Purpose: register and frame tests for the slot map
// Assumes: 4-bit words so a frame is 256 bits
// Notes:   fields 31, 32, 63, 0 put words at the same bits in every format
`timescale 1ns/1ps
module tb_acsm_slot_map;
    import acsm_pkg::*;
    logic          clk;
    logic          nrst;
    acsm_reg_req_t reg_req;
    logic [7:0]    reg_rdata;
    acsm_fmt_t     fmt;
    logic [3:0]    chan_en;
    logic          smp_valid;
    logic          smp_ready;
    acsm_frame_t   smp_data;
    logic          bclk;
    logic          fsync;
    logic          sdout;
    logic          sdout_oe;
    int            err_count;
    int            tests_run;
    int            sl[4] = '{31, 32, 63, 0};
    acsm_frame_t   fr[4];
    acsm_fmt_t     fl[4] = '{ACSM_FMT_TDM, ACSM_FMT_I2S, ACSM_FMT_LJ, ACSM_FMT_TDM};
    logic [3:0]    el[4] = '{4'hf, 4'hb, 4'hf, 4'h0};
    logic [255:0]  ed;
    logic [255:0]  eo;
    acsm_slot_map #(.WORD_W(4)) i_acsm_slot_map (.clk(clk), .nrst(nrst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .fmt(fmt), .chan_en(chan_en), .smp_valid(smp_valid), .smp_ready(smp_ready),
        .smp_data(smp_data), .bclk(bclk), .fsync(fsync), .sdout(sdout), .sdout_oe(sdout_oe));
    acsm_host_model i_acsm_host_model (.bclk(bclk), .fsync(fsync), .sdout(sdout), .sdout_oe(sdout_oe));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_sim();
        if (err_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{we: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        reg_req.we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_req.addr <= a;
        @(negedge clk);
        chk("reg_rdata", 256'(reg_rdata), 256'(e));
    endtask : rd
    task automatic push(input acsm_frame_t f);
        int n;
        n = 0;
        @(posedge clk);
        smp_valid <= 1'b1;
        smp_data  <= f;
        @(negedge clk);
        while (smp_ready !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (n == 20000) begin
            err_count++;
            end_sim();
        end
        @(posedge clk);
        smp_valid <= 1'b0;
    endtask : push
    // slot n lands at stream bit 4n, right half included
    task automatic expect_frame(input acsm_frame_t f, input logic [3:0] en);
        ed = '0;
        eo = '0;
        for (int c = 0; c < 4; c++)
            for (int b = 0; b < 4; b++)
                if (en[c]) begin
                    ed[sl[c]*4+b] = f.sample[c][31-b];
                    eo[sl[c]*4+b] = 1'b1;
                end
        chk("sdout", i_acsm_host_model.cap_d, ed);
        chk("sdout_oe", i_acsm_host_model.cap_o, eo);
    endtask : expect_frame
    initial begin
        nrst      = 1'b0;
        // first register addressed through reset so the release edge reads its reset value
        reg_req   = '{we: 1'b0, addr: 8'h0b, wdata: 8'h00};
        fmt       = ACSM_FMT_TDM;
        chan_en   = 4'h0;
        smp_valid = 1'b0;
        smp_data  = '0;
        fr[0] = 128'h3000_0000_c000_0000_5000_0000_afff_ffff;
        fr[1] = 128'h6000_0000_9000_0000_e000_0000_1000_0000;
        fr[2] = 128'hb000_0000_2000_0000_7000_0000_d000_0000;
        fr[3] = '0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        for (int c = 0; c < 4; c++) rd(8'h0b + 8'(c), 8'(c));
        // reserved bits always written as zero
        for (int c = 0; c < 4; c++) wr(8'h0b + 8'(c), 8'(sl[c]));
        wr(8'h0a, 8'h3f);
        wr(8'h0f, 8'h3f);
        rd(8'h0f, 8'h00);
        for (int c = 0; c < 4; c++) rd(8'h0b + 8'(c), 8'(sl[c]));
        push(fr[0]);
        push(fr[1]);
        @(negedge clk);
        chk("smp_ready", 256'(smp_ready), 256'(1'b0));
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            fmt     <= fl[k];
            chan_en <= (k == 3) ? 4'hf : el[k];
            fork
                i_acsm_host_model.frame(fl[k]);
                if (k == 0) push(fr[2]);
            join
            expect_frame(fr[k], el[k]);
        end
        end_sim();
    end
endmodule : tb_acsm_slot_map

// file: hw/acsm_buf.sv
// Purpose: small valid/ready buffer in the sample path
// Assumes: DEPTH is a power of two
// Notes:   full and empty come from an occupancy count
`timescale 1ns/1ps
module acsm_buf #(
    parameter int unsigned DEPTH = 2
) (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire acsm_pkg::acsm_frame_t in_data,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output acsm_pkg::acsm_frame_t     out_data
);
    import acsm_pkg::*;

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    acsm_frame_t       mem_q [DEPTH];
    logic [AW-1:0]     wr_q;
    logic [AW-1:0]     rd_q;
    logic [AW:0]       cnt_q;
    logic              push;
    logic              pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : acsm_buf

// file: hw/acsm_pkg.sv
// Purpose: constants and types for the audio serial channel slot map
// Assumes: 8-bit register port, host supplies bit clock and frame sync
// Notes:   slot fields are 6 bits wide; bits 7 and 6 always read zero
package acsm_pkg;

    localparam int unsigned NCH      = 4;
    localparam int unsigned SAMPLE_W = 32;
    localparam int unsigned SLOT_W   = 6;
    localparam int unsigned HALF_W   = 5;
    localparam int unsigned CNT_W    = 7;
    localparam int unsigned REG_W    = 8;

    localparam logic [REG_W-1:0] FIRST_CHANNEL_SLOT_REGISTER_OFS = 8'h0b;
    localparam logic [REG_W-1:0] CHAN2_SLOT_SELECT_OFS           = 8'h0c;
    localparam logic [REG_W-1:0] CHAN3_SLOT_SELECT_OFS           = 8'h0d;
    localparam logic [REG_W-1:0] CHAN4_SLOT_SELECT_OFS           = 8'h0e;

    localparam logic [SLOT_W-1:0] FIRST_CHANNEL_SLOT_RST = 6'h00;
    localparam logic [SLOT_W-1:0] CHAN2_SLOT_RST         = 6'h01;
    localparam logic [SLOT_W-1:0] CHAN3_SLOT_RST         = 6'h02;
    localparam logic [SLOT_W-1:0] CHAN4_SLOT_RST         = 6'h03;

    localparam logic [1:0]       RSVD_RD     = 2'h0;
    localparam logic [REG_W-1:0] UNMAPPED_RD = 8'h00;
    localparam logic [CNT_W-1:0] TDM_SLOTS   = 7'h40;
    localparam logic [CNT_W-1:0] HALF_SLOTS  = 7'h20;

    typedef enum logic [1:0] {
        ACSM_FMT_TDM,
        ACSM_FMT_I2S,
        ACSM_FMT_LJ
    } acsm_fmt_t;

    typedef struct packed {
        logic [NCH-1:0][SAMPLE_W-1:0] sample;
    } acsm_frame_t;

    typedef struct packed {
        logic             we;
        logic [REG_W-1:0] addr;
        logic [REG_W-1:0] wdata;
    } acsm_reg_req_t;

endpackage : acsm_pkg

// file: hw/acsm_slot_map.sv
// Purpose: slot-mapped serial audio transmitter with slot select registers
// Assumes: host drives bit clock and frame sync; both are sampled by clk
// Notes:   data changes after a sampled bit clock fall, one bit after sync edge
`timescale 1ns/1ps
module acsm_slot_map #(
    parameter int unsigned WORD_W    = 32,
    parameter int unsigned BUF_DEPTH = 2
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire acsm_pkg::acsm_reg_req_t reg_req,
    output logic [acsm_pkg::REG_W-1:0] reg_rdata,
    input  wire acsm_pkg::acsm_fmt_t   fmt,
    input  wire logic [acsm_pkg::NCH-1:0] chan_en,
    input  wire logic                  smp_valid,
    output logic                       smp_ready,
    input  wire acsm_pkg::acsm_frame_t smp_data,
    input  wire logic                  bclk,
    input  wire logic                  fsync,
    output logic                       sdout,
    output logic                       sdout_oe
);
    import acsm_pkg::*;

    logic [SLOT_W-1:0] slot_field_q [NCH];
    logic [1:0]        bclk_sync_q;
    logic              bclk_prev_q;
    logic [1:0]        fsync_sync_q;
    logic              fs_prev_q;
    logic              rise;
    logic              fall;
    logic              start_q;
    logic              new_frame_q;
    logic              half_q;
    logic              cur_half_q;
    logic [CNT_W-1:0]  slot_q;
    logic [7:0]        bit_q;
    logic [SAMPLE_W-1:0] shift_q;
    logic              oe_q;
    acsm_frame_t       frame_q;
    logic              frame_ok_q;
    acsm_frame_t       buf_data;
    logic              buf_valid;
    logic              buf_pop;
    logic              load;
    logic [CNT_W-1:0]  nxt_slot;
    logic              nxt_half;
    logic [SLOT_W-1:0] eff;
    logic              in_range;
    logic              hit;
    logic [1:0]        hit_idx;
    acsm_frame_t       src_frame;
    logic              src_ok;

    // register index for an address, or NCH when unmapped
    function automatic int unsigned reg_index(input logic [REG_W-1:0] a);
        unique case (a)
            FIRST_CHANNEL_SLOT_REGISTER_OFS: return 0;
            CHAN2_SLOT_SELECT_OFS:           return 1;
            CHAN3_SLOT_SELECT_OFS:           return 2;
            CHAN4_SLOT_SELECT_OFS:           return 3;
            default:                         return NCH;
        endcase
    endfunction : reg_index

    function automatic logic [SLOT_W-1:0] reset_slot(input int unsigned c);
        unique case (c)
            0:       return FIRST_CHANNEL_SLOT_RST;
            1:       return CHAN2_SLOT_RST;
            2:       return CHAN3_SLOT_RST;
            default: return CHAN4_SLOT_RST;
        endcase
    endfunction : reset_slot

    // slot select registers, one per channel
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_reg
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    slot_field_q[c] <= reset_slot(c);
                end else if (reg_req.we && reg_index(reg_req.addr) == c) begin
                    slot_field_q[c] <= reg_req.wdata[SLOT_W-1:0];
                end
            end
        end
    endgenerate

    always_comb begin
        if (reg_index(reg_req.addr) < NCH) begin
            reg_rdata = {RSVD_RD, slot_field_q[reg_index(reg_req.addr)]};
        end else begin
            reg_rdata = UNMAPPED_RD;
        end
    end

    // pin synchronisers and edge detection
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bclk_sync_q  <= '0;
            bclk_prev_q  <= 1'b0;
            fsync_sync_q <= '0;
        end else begin
            bclk_sync_q  <= {bclk_sync_q[0], bclk};
            bclk_prev_q  <= bclk_sync_q[1];
            fsync_sync_q <= {fsync_sync_q[0], fsync};
        end
    end

    assign rise = bclk_sync_q[1] && !bclk_prev_q;
    assign fall = !bclk_sync_q[1] && bclk_prev_q;

    // frame and half-frame start found at bit clock rise
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fs_prev_q   <= 1'b0;
            start_q     <= 1'b0;
            new_frame_q <= 1'b0;
            half_q      <= 1'b0;
        end else if (rise) begin
            fs_prev_q <= fsync_sync_q[1];
            if (fmt == ACSM_FMT_TDM) begin
                if (fsync_sync_q[1] && !fs_prev_q) begin
                    start_q     <= 1'b1;
                    new_frame_q <= 1'b1;
                    half_q      <= 1'b0;
                end
            end else if (fsync_sync_q[1] != fs_prev_q) begin
                // i2s: left half while sync low; lj: left half while sync high
                start_q     <= 1'b1;
                half_q      <= (fmt == ACSM_FMT_I2S) ? fsync_sync_q[1] : !fsync_sync_q[1];
                new_frame_q <= (fmt == ACSM_FMT_I2S) ? !fsync_sync_q[1] : fsync_sync_q[1];
            end
        end else if (fall) begin
            start_q     <= 1'b0;
            new_frame_q <= 1'b0;
        end
    end

    // slot position and word selection for the next fall
    always_comb begin
        load     = 1'b0;
        nxt_slot = slot_q;
        nxt_half = cur_half_q;
        if (start_q) begin
            load     = 1'b1;
            nxt_slot = '0;
            nxt_half = half_q;
        end else if (bit_q == 8'(WORD_W - 1)) begin
            load = 1'b1;
            if (slot_q != TDM_SLOTS) begin
                nxt_slot = slot_q + CNT_W'(1);
            end
        end
        if (fmt == ACSM_FMT_TDM) begin
            in_range = (nxt_slot < TDM_SLOTS);
            eff      = nxt_slot[SLOT_W-1:0];
        end else begin
            in_range = (nxt_slot < HALF_SLOTS);
            eff      = {nxt_half, nxt_slot[HALF_W-1:0]};
        end
        hit     = 1'b0;
        hit_idx = '0;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (chan_en[c] && in_range && slot_field_q[c] == eff) begin
                hit     = 1'b1;
                hit_idx = 2'(c);
            end
        end
        src_frame = (start_q && new_frame_q) ? buf_data : frame_q;
        src_ok    = (start_q && new_frame_q) ? buf_valid : frame_ok_q;
    end

    assign buf_pop = fall && start_q && new_frame_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            frame_q    <= '0;
            frame_ok_q <= 1'b0;
        end else if (buf_pop) begin
            frame_q    <= buf_data;
            frame_ok_q <= buf_valid;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bit_q      <= '0;
            slot_q     <= TDM_SLOTS;
            cur_half_q <= 1'b0;
        end else if (fall) begin
            slot_q     <= nxt_slot;
            cur_half_q <= nxt_half;
            bit_q      <= load ? '0 : bit_q + 8'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            shift_q <= '0;
            oe_q    <= 1'b0;
        end else if (fall) begin
            if (load) begin
                shift_q <= (hit && src_ok) ? src_frame.sample[hit_idx] : '0;
                oe_q    <= hit && src_ok;
            end else begin
                shift_q <= {shift_q[SAMPLE_W-2:0], 1'b0};
            end
        end
    end

    assign sdout    = shift_q[SAMPLE_W-1];
    assign sdout_oe = oe_q;

    acsm_buf #(
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (smp_valid),
        .in_ready  (smp_ready),
        .in_data   (smp_data),
        .out_valid (buf_valid),
        .out_ready (buf_pop),
        .out_data  (buf_data)
    );

endmodule : acsm_slot_map
